// ---- src/nso_pkg.sv ----
// Purpose: Shared constants and carrier types for oscillator select and overrange logic
// Assumes: Single 50 MHz sample-domain clock
// Notes: Widths are defaults; modules take parameters where sensible
package nso_pkg;
	// ----------------------------------------
	// Widths and settings
	// ----------------------------------------
	localparam int SAMPLE_W = 12; // Sample width, signed two's complement
	localparam int MAG_W = 12; // Magnitude and threshold width
	localparam int HOLD_W = 8; // Hold length counter width
	localparam int PHASE_W = 32; // Oscillator phase accumulator width
	localparam int NUM_OSC = 4; // Oscillators per downconverter
	localparam logic OSC_SRC_PINS = 1'h1; // Select source value that lets the pins steer
	localparam logic [1:0] OSC_SEL_RESET = 2'h0; // Selection after reset
	localparam logic [PHASE_W-1:0] PHASE_RESET = 32'h0; // Phase after reset

	// ----------------------------------------
	// Carrier types
	// ----------------------------------------
	typedef struct packed {
		logic sel_high; // High selection bit
		logic sel_low; // Low selection bit
	} nso_sel_pins_t;

	typedef struct packed {
		logic [MAG_W-1:0] thr_zero; // First threshold
		logic [MAG_W-1:0] thr_one; // Second threshold
		logic [HOLD_W-1:0] hold_len; // Minimum high time in cycles
	} nso_over_cfg_t;

	typedef logic [NUM_OSC-1:0][PHASE_W-1:0] nso_phase_set_t;
endpackage

// ---- src/nso_over_det.sv ----
// Purpose: One channel of two-threshold overrange detection with hold
// Assumes: Sample arrives in the CLK domain
// Notes: Outputs are registered
`timescale 1ns/1ps
module nso_over_det #(
	parameter int SW = nso_pkg::SAMPLE_W
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic signed [SW-1:0] sample,
	input wire nso_pkg::nso_over_cfg_t cfg,
	output logic [1:0] flag
);
	import nso_pkg::*;

	// ----------------------------------------
	// Magnitude
	// ----------------------------------------
	logic [SW-1:0] mag; // Absolute value of sample
	logic [1:0] exceed; // Per-threshold exceedance
	logic [1:0][HOLD_W-1:0] cnt; // Remaining hold cycles

	// Absolute value, most negative saturates
	always_comb begin
		if (sample[SW-1]) begin
			mag = (sample == {1'b1, {(SW-1){1'b0}}}) ? {1'b0, {(SW-1){1'b1}}} : SW'(-sample);
		end else begin
			mag = sample;
		end
		exceed[0] = MAG_W'(mag) > cfg.thr_zero;
		exceed[1] = MAG_W'(mag) > cfg.thr_one;
	end

	// ----------------------------------------
	// Hold counters and flags
	// ----------------------------------------
	for (genvar g = 0; g < 2; g++) begin : g_thr
		// Set on exceedance, reload hold, fall after full quiet hold
		always_ff @(posedge clk or negedge arst_n) begin
			if (!arst_n) begin
				cnt[g] <= '0;
				flag[g] <= 1'b0;
			end else if (exceed[g]) begin
				cnt[g] <= cfg.hold_len;
				flag[g] <= 1'b1;
			end else if (cnt[g] != '0) begin
				cnt[g] <= cnt[g] - 1'b1;
				flag[g] <= 1'b1;
			end else begin
				flag[g] <= 1'b0;
			end
		end

		// Flag stays up three edges at least whenever hold is three or more
		a_over_hold: assert property (@(posedge clk) disable iff (!arst_n)
			arst_n && exceed[g] && cfg.hold_len >= 8'h3 |=> flag[g] [*3])
			else $error("overrange flag fell before hold elapsed");

		// Exceedance raises the flag on the next edge
		a_over_rise: assert property (@(posedge clk) disable iff (!arst_n)
			arst_n && exceed[g] |=> flag[g]) else $error("overrange flag did not rise");
		// Quiet sample with spent hold lets the flag fall
		a_over_fall: assert property (@(posedge clk) disable iff (!arst_n)
			arst_n && !exceed[g] && cnt[g] == '0 |=> !flag[g]) else $error("overrange flag did not fall");
	end
endmodule

// ---- src/nso_top.sv ----
// Purpose: Oscillator select pins and overrange status outputs for two channels
// Assumes: Select pins asynchronous; samples and settings synchronous to CLK
// Notes: Oscillator phases advance every cycle whether selected or not
//
// Summary of operation
// - Two pin bits pick one of four oscillators
// - Each channel has its own selection pins
// - Unselected oscillators keep advancing their phase
// - Pins swap oscillator only when source equals one
// - Select pins synchronised before use
// - Two overrange outputs per channel, two thresholds
// - Output rises when magnitude exceeds threshold
// - Output held high at least hold length
`timescale 1ns/1ps
module nso_top #(
	parameter int PW = nso_pkg::PHASE_W
) (
	input wire logic CLK,
	input wire logic ARST_N,
	input wire nso_pkg::nso_sel_pins_t CHAN_A_OSC_SEL,
	input wire nso_pkg::nso_sel_pins_t CHAN_B_OSC_SEL,
	input wire logic OSC_SELECT_SOURCE,
	input wire logic COMPLEX_FORMAT,
	input wire logic [1:0] REG_SEL_A,
	input wire logic [1:0] REG_SEL_B,
	input wire nso_pkg::nso_phase_set_t FREQ_WORD_A,
	input wire nso_pkg::nso_phase_set_t FREQ_WORD_B,
	input wire logic signed [nso_pkg::SAMPLE_W-1:0] SAMPLE_A,
	input wire logic signed [nso_pkg::SAMPLE_W-1:0] SAMPLE_B,
	input wire nso_pkg::nso_over_cfg_t OVER_CFG,
	output logic [1:0] ACTIVE_OSC_A,
	output logic [1:0] ACTIVE_OSC_B,
	output logic MIXER_EN_A,
	output logic MIXER_EN_B,
	output logic [PW-1:0] MIX_PHASE_A,
	output logic [PW-1:0] MIX_PHASE_B,
	output logic CHAN_A_OVER_FLAG_ZERO,
	output logic CHAN_A_OVER_FLAG_ONE,
	output logic CHAN_B_OVER_FLAG_ZERO,
	output logic CHAN_B_OVER_FLAG_ONE
);
	import nso_pkg::*;

	// ----------------------------------------
	// Reset history
	// ----------------------------------------
	logic [1:0] rst_age; // Ones shifted in after release, guards history checks

	// Fills with ones so checks skip edges whose history reaches into reset
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rst_age <= 2'h0;
		end else begin
			rst_age <= {rst_age[0], 1'b1};
		end
	end

	// ----------------------------------------
	// Select pin synchronisers
	// ----------------------------------------
	logic [1:0] sync1_a; // First stage, read only by second stage
	logic [1:0] sync1_b; // First stage, read only by second stage
	logic [1:0] sync2_a; // Safe copy of channel A pins
	logic [1:0] sync2_b; // Safe copy of channel B pins

	// Two-flop synchroniser on all four pins
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			sync1_a <= 2'h0;
			sync1_b <= 2'h0;
			sync2_a <= 2'h0;
			sync2_b <= 2'h0;
		end else begin
			sync1_a <= {CHAN_A_OSC_SEL.sel_high, CHAN_A_OSC_SEL.sel_low};
			sync1_b <= {CHAN_B_OSC_SEL.sel_high, CHAN_B_OSC_SEL.sel_low};
			sync2_a <= sync1_a;
			sync2_b <= sync1_b;
		end
	end

	// ----------------------------------------
	// Oscillator selection
	// ----------------------------------------
	logic [1:0] next_sel_a; // Chosen oscillator, channel A
	logic [1:0] next_sel_b; // Chosen oscillator, channel B

	// Pins steer only when source setting says so, else register choice
	always_comb begin
		next_sel_a = (OSC_SELECT_SOURCE == OSC_SRC_PINS) ? sync2_a : REG_SEL_A;
		next_sel_b = (OSC_SELECT_SOURCE == OSC_SRC_PINS) ? sync2_b : REG_SEL_B;
	end

	// Register active selection per channel
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ACTIVE_OSC_A <= OSC_SEL_RESET;
			ACTIVE_OSC_B <= OSC_SEL_RESET;
			MIXER_EN_A <= 1'b0;
			MIXER_EN_B <= 1'b0;
		end else begin
			ACTIVE_OSC_A <= next_sel_a;
			ACTIVE_OSC_B <= next_sel_b;
			MIXER_EN_A <= COMPLEX_FORMAT;
			MIXER_EN_B <= COMPLEX_FORMAT;
		end
	end

	// ----------------------------------------
	// Free-running phase accumulators
	// ----------------------------------------
	nso_phase_set_t phase_a; // All channel A oscillator phases
	nso_phase_set_t phase_b; // All channel B oscillator phases

	for (genvar k = 0; k < NUM_OSC; k++) begin : g_osc
		// Every oscillator advances each cycle, selected or not
		always_ff @(posedge CLK or negedge ARST_N) begin
			if (!ARST_N) begin
				phase_a[k] <= PHASE_RESET;
				phase_b[k] <= PHASE_RESET;
			end else begin
				phase_a[k] <= phase_a[k] + FREQ_WORD_A[k];
				phase_b[k] <= phase_b[k] + FREQ_WORD_B[k];
			end
		end

		a_osc_advance: assert property (@(posedge CLK) disable iff (!ARST_N)
			rst_age[0] |-> phase_a[k] == $past(phase_a[k]) + $past(FREQ_WORD_A[k])
			&& phase_b[k] == $past(phase_b[k]) + $past(FREQ_WORD_B[k]))
			else $error("unselected oscillator stopped advancing");
	end

	// Mixer phase taken from the selected oscillator
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			MIX_PHASE_A <= '0;
			MIX_PHASE_B <= '0;
		end else begin
			MIX_PHASE_A <= PW'(phase_a[next_sel_a]);
			MIX_PHASE_B <= PW'(phase_b[next_sel_b]);
		end
	end

	// ----------------------------------------
	// Overrange detectors
	// ----------------------------------------
	logic [1:0] flag_a; // Channel A flags
	logic [1:0] flag_b; // Channel B flags

	nso_over_det u_over_a (
		.clk(CLK),
		.arst_n(ARST_N),
		.sample(SAMPLE_A),
		.cfg(OVER_CFG),
		.flag(flag_a)
	);

	nso_over_det u_over_b (
		.clk(CLK),
		.arst_n(ARST_N),
		.sample(SAMPLE_B),
		.cfg(OVER_CFG),
		.flag(flag_b)
	);

	// Detector flags are registered; direct output mapping
	always_comb begin
		CHAN_A_OVER_FLAG_ZERO = flag_a[0];
		CHAN_A_OVER_FLAG_ONE = flag_a[1];
		CHAN_B_OVER_FLAG_ZERO = flag_b[0];
		CHAN_B_OVER_FLAG_ONE = flag_b[1];
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// Channel A shows its pins three edges later while pins steer
	a_pin_follow: assert property (@(posedge CLK) disable iff (!ARST_N)
		rst_age[1] && OSC_SELECT_SOURCE
		|=> ACTIVE_OSC_A == $past(CHAN_A_OSC_SEL, 3))
		else $error("pin selection not followed");
	// Channel B follows its own pins, apart from channel A
	a_pin_follow_b: assert property (@(posedge CLK) disable iff (!ARST_N)
		rst_age[1] && OSC_SELECT_SOURCE
		|=> ACTIVE_OSC_B == $past(CHAN_B_OSC_SEL, 3))
		else $error("channel B pin selection not followed");

	// Register choice steers and pins are ignored while source is zero
	a_reg_hold: assert property (@(posedge CLK) disable iff (!ARST_N)
		ARST_N && !OSC_SELECT_SOURCE
		|=> ACTIVE_OSC_B == $past(REG_SEL_B))
		else $error("pins steered while disabled");
	a_reg_hold_a: assert property (@(posedge CLK) disable iff (!ARST_N)
		ARST_N && !OSC_SELECT_SOURCE
		|=> ACTIVE_OSC_A == $past(REG_SEL_A))
		else $error("channel A pins steered while disabled");

	// Two flops stand between each pin and the selection logic
	a_sync_delay: assert property (@(posedge CLK) disable iff (!ARST_N)
		ARST_N
		|-> ##2 sync2_a == $past(CHAN_A_OSC_SEL, 2))
		else $error("synchroniser depth wrong");
	a_sync_delay_b: assert property (@(posedge CLK) disable iff (!ARST_N)
		ARST_N
		|-> ##2 sync2_b == $past(CHAN_B_OSC_SEL, 2))
		else $error("channel B synchroniser depth wrong");

	// Mixer phase comes from the oscillator chosen one edge before
	a_mix_phase: assert property (@(posedge CLK) disable iff (!ARST_N)
		rst_age[0]
		|-> MIX_PHASE_B == $past(phase_b[next_sel_b]))
		else $error("mixer phase from wrong oscillator");
	a_mix_phase_a: assert property (@(posedge CLK) disable iff (!ARST_N)
		rst_age[0]
		|-> MIX_PHASE_A == $past(phase_a[next_sel_a]))
		else $error("channel A mixer phase from wrong oscillator");

	// Mixers run only while the complex format is active
	a_mixer_enable: assert property (@(posedge CLK) disable iff (!ARST_N)
		rst_age[0]
		|-> MIXER_EN_A == $past(COMPLEX_FORMAT) && MIXER_EN_B == $past(COMPLEX_FORMAT))
		else $error("mixer enable does not follow complex format");
endmodule

// ---- tb/nso_board.sv ----
// Purpose: Board logic that hops the select pins and watches the flags
// Assumes: Pins move between clock edges, unrelated to sampling
// Notes: Hops only while hop_en is high
`timescale 1ns/1ps
module nso_board (
	input wire logic clk,
	input wire logic hop_en,
	input wire logic [3:0] flags,
	output nso_pkg::nso_sel_pins_t sel_a,
	output nso_pkg::nso_sel_pins_t sel_b,
	output int rises
);
	import nso_pkg::*;
	// ----------------------------------------
	// Pin hopping
	// ----------------------------------------
	initial begin
		sel_a = '0;
		sel_b = '0;
		rises = 0;
		forever begin
			repeat ($urandom % 9 + 1) @(posedge clk);
			#7;
			if (hop_en) begin
				sel_a = nso_sel_pins_t'(2'($urandom));
				sel_b = nso_sel_pins_t'(2'($urandom));
			end
		end
	end
	// Counts flag activity
	always @(flags) rises++;
endmodule

// ---- tb/nso_top_tb.sv ----
// Purpose: Self-checking bench comparing the block against a reference
// Assumes: Reference sees inputs as sampled at each rising edge
// Notes: Flags, selection, phase and enables checked every cycle
`timescale 1ns/1ps
module nso_top_tb;
	import nso_pkg::*;
	logic CLK = 1'b0;
	logic ARST_N = 1'b0;
	logic src = 1'b0;
	logic cplx = 1'b0;
	logic hop = 1'b1;
	logic [1:0] rs [2] = '{2'h0, 2'h0};
	nso_phase_set_t fw [2] = '{'0, '0};
	logic signed [11:0] smp [2] = '{12'h000, 12'h000};
	nso_over_cfg_t cfg = '{12'h3e8, 12'h708, 8'h00};
	nso_sel_pins_t sel_a, sel_b;
	logic [1:0] act_a, act_b;
	logic en_a, en_b;
	logic [31:0] ph_a, ph_b;
	logic [3:0] fl;
	int n_fail = 0;
	int checked = 0;
	int unsigned m_ph [2][4];
	int m_s1 [2], m_s2 [2], m_act [2], m_en [2], m_cnt [2][2], m_fl [2][2];
	int unsigned m_mix [2];
	int nsel, mag;
	int n_rise;
	logic [7:0] holds [4] = '{8'h00, 8'h01, 8'h05, 8'h28};
	always #10 CLK = ~CLK;
	nso_top DUT (.CLK(CLK), .ARST_N(ARST_N), .CHAN_A_OSC_SEL(sel_a), .CHAN_B_OSC_SEL(sel_b),
		.OSC_SELECT_SOURCE(src), .COMPLEX_FORMAT(cplx), .REG_SEL_A(rs[0]), .REG_SEL_B(rs[1]),
		.FREQ_WORD_A(fw[0]), .FREQ_WORD_B(fw[1]), .SAMPLE_A(smp[0]), .SAMPLE_B(smp[1]),
		.OVER_CFG(cfg), .ACTIVE_OSC_A(act_a), .ACTIVE_OSC_B(act_b), .MIXER_EN_A(en_a),
		.MIXER_EN_B(en_b), .MIX_PHASE_A(ph_a), .MIX_PHASE_B(ph_b), .CHAN_A_OVER_FLAG_ZERO(fl[0]),
		.CHAN_A_OVER_FLAG_ONE(fl[1]), .CHAN_B_OVER_FLAG_ZERO(fl[2]), .CHAN_B_OVER_FLAG_ONE(fl[3]));
	nso_board BRD (.clk(CLK), .hop_en(hop), .flags(fl), .sel_a(sel_a), .sel_b(sel_b), .rises(n_rise));
	// ----------------------------------------
	// Reference model
	// ----------------------------------------
	always @(posedge CLK or negedge ARST_N) begin
		for (int c = 0; c < 2; c++) begin
			nsel = src ? m_s2[c] : rs[c];
			m_mix[c] = ARST_N ? m_ph[c][nsel] : 0;
			m_act[c] = ARST_N ? nsel : 0;
			m_s2[c] = ARST_N ? m_s1[c] : 0;
			m_s1[c] = ARST_N ? int'(c ? sel_b : sel_a) : 0;
			m_en[c] = ARST_N ? cplx : 0;
			for (int k = 0; k < 4; k++) m_ph[c][k] = ARST_N ? m_ph[c][k] + fw[c][k] : 0;
			mag = (smp[c] < 0) ? -int'(smp[c]) : int'(smp[c]);
			mag = (mag > 2047) ? 2047 : mag;
			for (int t = 0; t < 2; t++) begin
				if (!ARST_N) begin
					m_fl[c][t] = 0;
					m_cnt[c][t] = 0;
				end else if (mag > int'(t ? cfg.thr_one : cfg.thr_zero)) begin
					m_fl[c][t] = 1;
					m_cnt[c][t] = cfg.hold_len;
				end else if (m_cnt[c][t] > 0) m_cnt[c][t]--;
				else m_fl[c][t] = 0;
			end
		end
	end
	// ----------------------------------------
	// Comparison
	// ----------------------------------------
	task automatic chk_w(string n, logic [31:0] e, logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic chk_b(string n, logic e, logic g);
		chk_w(n, {31'h0, e}, {31'h0, g});
	endtask
	always @(negedge CLK) begin
		if (ARST_N) begin
			chk_w("act_a", m_act[0], act_a);
			chk_w("act_b", m_act[1], act_b);
			chk_w("phase_a", m_mix[0], ph_a);
			chk_w("phase_b", m_mix[1], ph_b);
			chk_b("en_a", m_en[0][0], en_a);
			chk_b("en_b", m_en[1][0], en_b);
			for (int i = 0; i < 4; i++) chk_b("flag", m_fl[i / 2][i % 2][0], fl[i]);
		end
	end
	// Sample picker with threshold boundaries
	function automatic logic [11:0] pick();
		case ($urandom % 6)
			0: return cfg.thr_zero;
			1: return -(cfg.thr_one + 12'h001);
			2: return 12'h800;
			3: return cfg.thr_zero + 12'h001;
			default: return 12'($urandom % 512);
		endcase
	endfunction
	task automatic conclude();
		if (n_fail == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// ----------------------------------------
	// Stimulus
	// ----------------------------------------
	initial begin
		void'($urandom(83));
		repeat (16) @(posedge CLK);
		ARST_N <= 1'b1;
		for (int p = 0; p < 4; p++) begin
			if (p == 2) begin
				ARST_N <= 1'b0;
				repeat (3) @(posedge CLK);
				ARST_N <= 1'b1;
			end
			cfg.hold_len <= holds[p];
			repeat (1500) begin
				@(posedge CLK);
				src <= ($urandom % 64) ? src : ~src;
				cplx <= ($urandom % 32) ? cplx : ~cplx;
				hop <= ($urandom % 8) != 0;
				for (int c = 0; c < 2; c++) begin
					rs[c] <= 2'($urandom);
					smp[c] <= pick();
					if ($urandom % 100 == 0) fw[c][$urandom % 4] <= $urandom;
				end
			end
		end
		chk_b("flag_activity", 1'b1, n_rise > 0);
		conclude();
	end
	// Watchdog
	initial begin
		#200000;
		n_fail++;
		conclude();
	end
endmodule
